// ---- hw/gpcl_pkg.sv ----
// Package for the GPIO port configuration and lock block
package gpcl_pkg;
	localparam int          PINS         = 16;
	localparam logic [7:0]  OFS_CFG_LO   = 8'h00;
	localparam logic [7:0]  OFS_CFG_HI   = 8'h04;
	localparam logic [7:0]  OFS_IN       = 8'h08;
	localparam logic [7:0]  OFS_OUT      = 8'h0C;
	localparam logic [7:0]  OFS_SETCLR   = 8'h10;
	localparam logic [7:0]  OFS_CLR      = 8'h14;
	localparam logic [7:0]  OFS_LOCK     = 8'h18;
	localparam logic [31:0] CFG_RESET    = 32'h4444_4444;
	localparam logic [15:0] HALF_ZERO    = 16'h0000;
	localparam int          KEY_BIT      = 16;
	localparam int          CLR_SHIFT    = 16;
	localparam int          FIELD_W      = 4;
	// Mode field codes
	localparam logic [1:0]  MODE_INPUT   = 2'h0;
	localparam logic [1:0]  MODE_OUT_10M = 2'h1;
	localparam logic [1:0]  MODE_OUT_2M  = 2'h2;
	localparam logic [1:0]  MODE_OUT_50M = 2'h3;
	// Config field codes, input mode
	localparam logic [1:0]  CFG_ANALOG   = 2'h0;
	localparam logic [1:0]  CFG_FLOAT    = 2'h1;
	localparam logic [1:0]  CFG_PULL     = 2'h2;
	// Config field bits, output mode
	localparam int          CFG_OD_BIT   = 0;
	localparam int          CFG_AF_BIT   = 1;
	typedef enum logic [1:0]
	{
		KEY_IDLE  = 2'b00,
		KEY_ONE   = 2'b01,
		KEY_ZERO  = 2'b10,
		KEY_ARMED = 2'b11
	} gpcl_key_type;
endpackage : gpcl_pkg

// ---- hw/gpcl_port.sv ----
// GPIO port with configuration, data, set/clear and lock registers on APB
`timescale 1ns/100ps
`default_nettype none
module gpcl_port
(
	// Clock, reset and enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pins
	input  wire logic [15:0] pin_in,
	output logic      [15:0] pin_out,
	output logic      [15:0] pin_oe_n,
	output logic      [15:0] pin_pull_en,
	output logic      [15:0] pin_analog,
	output logic      [31:0] pin_speed,
	// Alternate function sources
	input  wire logic [15:0] alt_out
);
	logic [31:0]              cfg_lo_q;
	logic [31:0]              cfg_hi_q;
	logic [15:0]              out_q;
	logic [15:0]              lock_q;
	logic                     key_q;
	gpcl_pkg::gpcl_key_type   key_st_q;
	logic [15:0]              in_meta_q;
	logic [15:0]              in_sync_q;
	logic [31:0]              rdata_d;
	logic                     access;
	logic                     wr;
	logic                     rd;
	logic                     mapped;
	logic [31:0]              wmask_lo;
	logic [31:0]              wmask_hi;
	logic [63:0]              cfg_all;
	logic                     key_w;
	logic [31:0]              pin_mode_all;
	logic [31:0]              pin_cfg_all;
	logic [15:0]              pin_pull_sel;
	logic [15:0]              pin_ana_sel;
	logic [15:0]              pin_od_sel;
	logic [15:0]              pin_val;

	// Zero-wait slave: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign access  = psel & penable & clk_en;
	assign wr      = access & pwrite;
	assign rd      = access & ~pwrite;
	assign key_w   = pwdata[gpcl_pkg::KEY_BIT];
	assign cfg_all = {cfg_hi_q, cfg_lo_q};

	always_comb
	begin
		unique case (paddr)
			gpcl_pkg::OFS_CFG_LO,
			gpcl_pkg::OFS_CFG_HI,
			gpcl_pkg::OFS_IN,
			gpcl_pkg::OFS_OUT,
			gpcl_pkg::OFS_SETCLR,
			gpcl_pkg::OFS_CLR,
			gpcl_pkg::OFS_LOCK: mapped = 1'b1;
			default:            mapped = 1'b0;
		endcase
	end

	assign pslverr = psel & penable & ~mapped;

	// Write masks: a locked pin freezes its whole 4-bit group
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			wmask_lo[i*gpcl_pkg::FIELD_W +: gpcl_pkg::FIELD_W] =
				{gpcl_pkg::FIELD_W{~(key_q & lock_q[i])}};
			wmask_hi[i*gpcl_pkg::FIELD_W +: gpcl_pkg::FIELD_W] =
				{gpcl_pkg::FIELD_W{~(key_q & lock_q[i+8])}};
		end
	end

	// Pin input synchroniser; the first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			in_meta_q <= gpcl_pkg::HALF_ZERO;
			in_sync_q <= gpcl_pkg::HALF_ZERO;
		end
		else if (clk_en)
		begin
			in_meta_q <= pin_in;
			in_sync_q <= in_meta_q;
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_lo_q <= gpcl_pkg::CFG_RESET;
			cfg_hi_q <= gpcl_pkg::CFG_RESET;
		end
		else if (wr && paddr == gpcl_pkg::OFS_CFG_LO)
			cfg_lo_q <= (cfg_lo_q & ~wmask_lo) | (pwdata & wmask_lo);
		else if (wr && paddr == gpcl_pkg::OFS_CFG_HI)
			cfg_hi_q <= (cfg_hi_q & ~wmask_hi) | (pwdata & wmask_hi);
	end

	// Output data, with set taking priority over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_q <= gpcl_pkg::HALF_ZERO;
		else if (wr && paddr == gpcl_pkg::OFS_OUT)
			out_q <= pwdata[15:0];
		else if (wr && paddr == gpcl_pkg::OFS_SETCLR)
			out_q <= (out_q & ~pwdata[gpcl_pkg::CLR_SHIFT +: 16]) | pwdata[15:0];
		else if (wr && paddr == gpcl_pkg::OFS_CLR)
			out_q <= out_q & ~pwdata[15:0];
	end

	// Lock key sequence: write 1, write 0, write 1, then read arms it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			key_st_q <= gpcl_pkg::KEY_IDLE;
			key_q    <= 1'b0;
			lock_q   <= gpcl_pkg::HALF_ZERO;
		end
		else if (access && paddr == gpcl_pkg::OFS_LOCK && !key_q)
		begin
			if (wr)
				lock_q <= pwdata[15:0];
			unique case (key_st_q)
				gpcl_pkg::KEY_IDLE:
					key_st_q <= (wr && key_w) ? gpcl_pkg::KEY_ONE : gpcl_pkg::KEY_IDLE;
				gpcl_pkg::KEY_ONE:
					key_st_q <= (wr && !key_w && pwdata[15:0] == lock_q)
						? gpcl_pkg::KEY_ZERO : gpcl_pkg::KEY_IDLE;
				gpcl_pkg::KEY_ZERO:
					key_st_q <= (wr && key_w && pwdata[15:0] == lock_q)
						? gpcl_pkg::KEY_ARMED : gpcl_pkg::KEY_IDLE;
				gpcl_pkg::KEY_ARMED:
				begin
					// The read of this step still returns 0; key goes active after it
					if (rd)
						key_q <= 1'b1;
					else
						key_st_q <= (key_w) ? gpcl_pkg::KEY_ONE : gpcl_pkg::KEY_IDLE;
				end
			endcase
		end
	end

	// Read data
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		unique case (paddr)
			gpcl_pkg::OFS_CFG_LO: rdata_d = cfg_lo_q;
			gpcl_pkg::OFS_CFG_HI: rdata_d = cfg_hi_q;
			gpcl_pkg::OFS_IN:     rdata_d = {gpcl_pkg::HALF_ZERO, in_sync_q};
			gpcl_pkg::OFS_OUT:    rdata_d = {gpcl_pkg::HALF_ZERO, out_q};
			gpcl_pkg::OFS_LOCK:   rdata_d = {15'h0000, key_q, lock_q};
			default:              rdata_d = 32'h0000_0000;
		endcase
	end

	// Read data registered on the setup cycle so it stands in the access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (clk_en && psel && !penable && !pwrite)
			prdata <= rdata_d;
	end

	// Per-pin decode sits here so the pin register stays purely non-blocking
	always_comb
	begin
		pin_mode_all = 32'h0000_0000;
		pin_cfg_all  = 32'h0000_0000;
		pin_pull_sel = gpcl_pkg::HALF_ZERO;
		pin_ana_sel  = gpcl_pkg::HALF_ZERO;
		pin_od_sel   = gpcl_pkg::HALF_ZERO;
		pin_val      = gpcl_pkg::HALF_ZERO;
		for (int i = 0; i < gpcl_pkg::PINS; i++)
		begin
			pin_mode_all[2*i +: 2] = cfg_all[i*gpcl_pkg::FIELD_W +: 2];
			pin_cfg_all[2*i +: 2]  = cfg_all[i*gpcl_pkg::FIELD_W + 2 +: 2];
			pin_pull_sel[i] = (pin_cfg_all[2*i +: 2] == gpcl_pkg::CFG_PULL);
			pin_ana_sel[i]  = (pin_cfg_all[2*i +: 2] == gpcl_pkg::CFG_ANALOG);
			pin_od_sel[i]   = pin_cfg_all[2*i + gpcl_pkg::CFG_OD_BIT];
			pin_val[i]      = pin_cfg_all[2*i + gpcl_pkg::CFG_AF_BIT]
				? alt_out[i] : out_q[i];
		end
	end

	// Pin drivers; registered so outputs are glitch free
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_out     <= gpcl_pkg::HALF_ZERO;
			pin_oe_n    <= {gpcl_pkg::PINS{1'b1}};
			pin_pull_en <= gpcl_pkg::HALF_ZERO;
			pin_analog  <= gpcl_pkg::HALF_ZERO;
			pin_speed   <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			for (int i = 0; i < gpcl_pkg::PINS; i++)
			begin
				pin_speed[2*i +: 2] <= pin_mode_all[2*i +: 2];
				if (pin_mode_all[2*i +: 2] == gpcl_pkg::MODE_INPUT)
				begin
					pin_out[i]     <= 1'b0;
					pin_oe_n[i]    <= 1'b1;
					pin_pull_en[i] <= pin_pull_sel[i];
					pin_analog[i]  <= pin_ana_sel[i];
				end
				else
				begin
					pin_pull_en[i] <= 1'b0;
					pin_analog[i]  <= 1'b0;
					pin_out[i]     <= pin_val[i];
					// Open drain only drives the low level
					pin_oe_n[i]    <= pin_od_sel[i] ? pin_val[i] : 1'b0;
				end
			end
		end
	end

	// Assertions: output data, set/clear and clear-only
	a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == gpcl_pkg::OFS_SETCLR && pwdata[0]) |=> out_q[0])
		else $error("set did not win");
	a_clr_only: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == gpcl_pkg::OFS_CLR && pwdata[3]) |=> !out_q[3])
		else $error("clear-only failed");
	a_setclr_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == gpcl_pkg::OFS_SETCLR && pwdata[17] && !pwdata[1]) |=> !out_q[1])
		else $error("set/clear clear failed");
	a_out_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == gpcl_pkg::OFS_OUT) |=> out_q == $past(pwdata[15:0]))
		else $error("output data write lost");
	a_set_all: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == gpcl_pkg::OFS_SETCLR)
		|=> (out_q & $past(pwdata[15:0])) == $past(pwdata[15:0]))
		else $error("set request not applied");
	a_set_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == gpcl_pkg::OFS_SETCLR) |=> ((out_q ^ $past(out_q))
		& ~($past(pwdata[15:0]) | $past(pwdata[31:16]))) == gpcl_pkg::HALF_ZERO)
		else $error("set/clear touched an idle pin");
	a_clr_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == gpcl_pkg::OFS_SETCLR) |=> (out_q
		& $past(pwdata[31:16]) & ~$past(pwdata[15:0])) == gpcl_pkg::HALF_ZERO)
		else $error("clear request not applied");
	a_clr_all: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == gpcl_pkg::OFS_CLR)
		|=> (out_q & $past(pwdata[15:0])) == gpcl_pkg::HALF_ZERO)
		else $error("clear-only bit not cleared");
	a_clr_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == gpcl_pkg::OFS_CLR)
		|=> ((out_q ^ $past(out_q)) & ~$past(pwdata[15:0])) == gpcl_pkg::HALF_ZERO)
		else $error("clear-only touched an idle pin");

	// Input data
	a_in_upper: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && psel && !penable && !pwrite && paddr == gpcl_pkg::OFS_IN)
		|=> prdata[31:16] == gpcl_pkg::HALF_ZERO)
		else $error("input upper half not zero");
	a_input_sync: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> in_sync_q == $past(in_meta_q))
		else $error("input synchroniser skipped a stage");

	// Lock key and lock bits
	a_key_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		key_q |=> key_q && $stable(lock_q))
		else $error("lock register changed after key");
	a_lock_freeze: assert property (@(posedge pclk) disable iff (!presetn)
		(key_q && lock_q[0]) |=> $stable(cfg_lo_q[3:0]))
		else $error("locked field changed");
	a_key_arms: assert property (@(posedge pclk) disable iff (!presetn)
		(!key_q && key_st_q == gpcl_pkg::KEY_ARMED && rd && paddr == gpcl_pkg::OFS_LOCK)
		|=> key_q)
		else $error("key did not arm");
	a_key_only_seq: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(key_q) |-> $past(key_st_q) == gpcl_pkg::KEY_ARMED)
		else $error("key armed outside sequence");
	a_lock_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == gpcl_pkg::OFS_LOCK && !key_q) |=> lock_q == $past(pwdata[15:0]))
		else $error("lock bits not written while key clear");
	a_key_readable: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && psel && !penable && !pwrite && paddr == gpcl_pkg::OFS_LOCK)
		|=> prdata[gpcl_pkg::KEY_BIT] == $past(key_q))
		else $error("key bit read back wrong");
	a_key_abandon: assert property (@(posedge pclk) disable iff (!presetn)
		(access && paddr == gpcl_pkg::OFS_LOCK && !key_q && key_st_q == gpcl_pkg::KEY_ZERO
		&& (!pwrite || !key_w || pwdata[15:0] != lock_q)) |=> key_st_q == gpcl_pkg::KEY_IDLE && !key_q)
		else $error("broken key sequence not abandoned");
	a_lock_all: assert property (@(posedge pclk) disable iff (!presetn)
		key_q |=> ((cfg_all ^ $past(cfg_all)) & ~{$past(wmask_hi), $past(wmask_lo)})
		== 64'h0000_0000_0000_0000)
		else $error("locked pin group changed");

	// Pin drivers
	a_od_high: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && cfg_lo_q[1:0] != gpcl_pkg::MODE_INPUT && cfg_lo_q[2]
		&& !cfg_lo_q[3] && out_q[0]) |=> pin_oe_n[0])
		else $error("open drain drove high");
	a_pp_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && cfg_lo_q[1:0] != gpcl_pkg::MODE_INPUT && !cfg_lo_q[2]) |=> !pin_oe_n[0])
		else $error("push-pull pin not driven");
	a_input_hiz: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && cfg_lo_q[1:0] == gpcl_pkg::MODE_INPUT) |=> pin_oe_n[0])
		else $error("input pin driven");
	a_speed_mode: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> pin_speed == $past(pin_mode_all))
		else $error("speed grade does not follow mode");
	a_pull_only_in: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> (pin_pull_en & ~pin_oe_n) == gpcl_pkg::HALF_ZERO)
		else $error("pull enabled on a driven pin");
	a_analog_only_in: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> (pin_analog & ~pin_oe_n) == gpcl_pkg::HALF_ZERO)
		else $error("analog set on a driven pin");
	// Clock enable low must hold the output data, config, lock and key registers and pin_oe_n, including a bus access in flight
	a_freeze: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(out_q) && $stable(cfg_lo_q) && $stable(cfg_hi_q)
		&& $stable(lock_q) && $stable(key_q) && $stable(pin_oe_n))
		else $error("state moved while clock enable low");

	c_lock: cover property (@(posedge pclk) disable iff (!presetn) $rose(key_q));
	c_setclr: cover property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == gpcl_pkg::OFS_SETCLR);
	c_abort: cover property (@(posedge pclk) disable iff (!presetn)
		key_st_q == gpcl_pkg::KEY_ZERO ##1 key_st_q == gpcl_pkg::KEY_IDLE);
	c_freeze: cover property (@(posedge pclk) disable iff (!presetn)
		!clk_en && psel && penable);
	c_od_release: cover property (@(posedge pclk) disable iff (!presetn)
		cfg_lo_q[1:0] != gpcl_pkg::MODE_INPUT && cfg_lo_q[2] && pin_oe_n[0]);
endmodule : gpcl_port
`default_nettype wire

// ---- sim/gpcl_port_tb_top.sv ----
// Self-checking testbench for the GPIO port block
`timescale 1ns/100ps
`default_nettype none
module gpcl_port_tb_top;
	logic        pclk;
	logic        presetn;
	logic        clk_en;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] pin_in;
	logic [15:0] pin_out;
	logic [15:0] pin_oe_n;
	logic [15:0] pin_pull_en;
	logic [15:0] pin_analog;
	logic [31:0] pin_speed;
	logic [15:0] alt_out;
	logic [31:0] rd;
	logic        er;
	int          err_count;
	int          tests_run;

	gpcl_port gpcl_port_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pin_pull_en(pin_pull_en), .pin_analog(pin_analog),
		.pin_speed(pin_speed), .alt_out(alt_out));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task stop_test;
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Bounded wait on pready so a dead slave ends the run instead of hanging it
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			err_count++;
			$display("[FAIL] pready expected 1 seen %b", pready);
			stop_test;
		end
	endtask : apb

	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask : rdchk

	task settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask : settle

	task t_reset;
		rdchk("cfg_lo", gpcl_pkg::OFS_CFG_LO, 32'h4444_4444);
		rdchk("cfg_hi", gpcl_pkg::OFS_CFG_HI, 32'h4444_4444);
		rdchk("out", gpcl_pkg::OFS_OUT, 32'h0000_0000);
		rdchk("lock", gpcl_pkg::OFS_LOCK, 32'h0000_0000);
		chk("oe_rst", 32'h0000_FFFF, {16'h0000, pin_oe_n});
		rdchk("unmapped", 8'h1C, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, {31'h0, er});
	endtask : t_reset

	task t_data;
		apb(1'b1, gpcl_pkg::OFS_OUT, 32'h0000_00FF);
		rdchk("out_rw", gpcl_pkg::OFS_OUT, 32'h0000_00FF);
		apb(1'b1, gpcl_pkg::OFS_SETCLR, 32'h0103_8001);
		rdchk("setclr", gpcl_pkg::OFS_OUT, 32'h0000_80FD);
		rdchk("setclr_rd", gpcl_pkg::OFS_SETCLR, 32'h0000_0000);
		apb(1'b1, gpcl_pkg::OFS_CLR, 32'h0000_0084);
		rdchk("clr", gpcl_pkg::OFS_OUT, 32'h0000_8079);
		rdchk("clr_rd", gpcl_pkg::OFS_CLR, 32'h0000_0000);
	endtask : t_data

	task t_input;
		pin_in <= 16'hA5C3;
		repeat (4) @(posedge pclk);
		apb(1'b1, gpcl_pkg::OFS_IN, 32'h0000_1111);
		rdchk("in", gpcl_pkg::OFS_IN, 32'h0000_A5C3);
	endtask : t_input

	// Pins 8..15: pp 10M, od 2M, af pp 50M, af od 50M, analog, float, pull, reserved
	task t_config;
		apb(1'b1, gpcl_pkg::OFS_OUT, 32'h0000_0300);
		alt_out <= 16'h0C00;
		apb(1'b1, gpcl_pkg::OFS_CFG_HI, 32'hC840_FB61);
		rdchk("cfg_hi_rw", gpcl_pkg::OFS_CFG_HI, 32'hC840_FB61);
		settle;
		chk("speed", 32'h0000_00F9, {16'h0, pin_speed[31:16]});
		chk("pull", 32'h0000_0040, {24'h0, pin_pull_en[15:8]});
		chk("analog", 32'h0000_0010, {24'h0, pin_analog[15:8]});
		chk("oe_hi", 32'h0000_00FA, {24'h0, pin_oe_n[15:8]});
		chk("out_hi", 32'h0000_0005, {29'h0, pin_out[10], 1'b0, pin_out[8]});
		apb(1'b1, gpcl_pkg::OFS_OUT, 32'h0000_0000);
		alt_out <= 16'h0000;
		settle;
		chk("oe_low", 32'h0000_00F0, {24'h0, pin_oe_n[15:8]});
		chk("out_low", 32'h0000_0000, {29'h0, pin_out[10], 1'b0, pin_out[8]});
		apb(1'b1, gpcl_pkg::OFS_CFG_LO, 32'h4444_4441);
		settle;
		chk("speed_lo", 32'h0000_0001, {30'h0, pin_speed[1:0]});
		chk("oe_lo", 32'h0000_0000, {31'h0, pin_oe_n[0]});
		apb(1'b1, gpcl_pkg::OFS_OUT, 32'h0000_0001);
		apb(1'b1, gpcl_pkg::OFS_CFG_LO, 32'h4444_4445);
		settle;
		chk("oe_od", 32'h0000_0001, {31'h0, pin_oe_n[0]});
		chk("out_od", 32'h0000_0001, {31'h0, pin_out[0]});
	endtask : t_config

	// Clock enable low: the access is not taken and nothing moves
	task t_freeze;
		clk_en <= 1'b0;
		apb(1'b1, gpcl_pkg::OFS_OUT, 32'h0000_FFFF);
		clk_en <= 1'b1;
		rdchk("out_frz", gpcl_pkg::OFS_OUT, 32'h0000_8079);
	endtask : t_freeze

	task t_lock;
		apb(1'b1, gpcl_pkg::OFS_LOCK, 32'h0001_0100);
		apb(1'b1, gpcl_pkg::OFS_LOCK, 32'h0000_0100);
		apb(1'b1, gpcl_pkg::OFS_LOCK, 32'h0001_0300);
		rdchk("lock_dev1", gpcl_pkg::OFS_LOCK, 32'h0000_0300);
		rdchk("lock_dev2", gpcl_pkg::OFS_LOCK, 32'h0000_0300);
		apb(1'b1, gpcl_pkg::OFS_LOCK, 32'h0001_0100);
		apb(1'b1, gpcl_pkg::OFS_LOCK, 32'h0000_0100);
		apb(1'b1, gpcl_pkg::OFS_LOCK, 32'h0001_0100);
		rdchk("lock_rd0", gpcl_pkg::OFS_LOCK, 32'h0000_0100);
		rdchk("lock_rd1", gpcl_pkg::OFS_LOCK, 32'h0001_0100);
		apb(1'b1, gpcl_pkg::OFS_LOCK, 32'h0000_0000);
		rdchk("lock_frz", gpcl_pkg::OFS_LOCK, 32'h0001_0100);
		apb(1'b1, gpcl_pkg::OFS_CFG_HI, 32'h4444_4443);
		rdchk("cfg_lock", gpcl_pkg::OFS_CFG_HI, 32'h4444_4441);
		apb(1'b1, gpcl_pkg::OFS_CFG_LO, 32'h4444_4443);
		rdchk("cfg_free", gpcl_pkg::OFS_CFG_LO, 32'h4444_4443);
	endtask : t_lock

	// Reset in mid-run lifts the lock and restores the reset values
	task t_relock;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("lock_rst", gpcl_pkg::OFS_LOCK, 32'h0000_0000);
		apb(1'b1, gpcl_pkg::OFS_CFG_HI, 32'h4444_4443);
		rdchk("cfg_unlock", gpcl_pkg::OFS_CFG_HI, 32'h4444_4443);
		rdchk("out_rst", gpcl_pkg::OFS_OUT, 32'h0000_0000);
	endtask : t_relock

	initial
	begin
		err_count = 0;
		tests_run = 0;
		presetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pin_in = 16'h0000;
		alt_out = 16'h0000;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_data;
		t_input;
		t_freeze;
		t_config;
		t_lock;
		t_relock;
		stop_test;
	end
endmodule : gpcl_port_tb_top
`default_nettype wire
